/* File: hw/bpwu_params.svh */
// bpwu_params.svh: offsets, field positions and codes of the breakpoint unit
// Contract
// - a write whose return field ends in eight ones gets no reply.
// - multi-byte message data travels most significant byte first.
// - first remote read operand holds the thread in bits 7:0, rest reserved.
// - second remote read operand holds the register in bits 4:0, rest reserved.
// - cause code: 1 host, 2 debug call, 3 break, 4 data watch, 5 resource watch.
// - comparator index field 17:16, zero for host and debug call causes.
// - simultaneous comparator hits report the lowest numbered comparator.
// - thread field 15:8 records the raising thread, zero for host requests.
// - four 32-bit instruction break addresses at consecutive offsets.
// - break control has thread mask 23:16 and enable bit 0.
// - mode bit 1 clear breaks on pc equal, set breaks on pc different.
// - four data watchpoints with first and second address banks.
// - data watch control has thread mask 23:16 and enable bit 0.
// - condition bit 1 combines the two address matches by AND or OR.
// - data watchpoints fire on loads only when control bit 2 is set.
// - four 32-bit resource watch mask registers.
// - four 32-bit resource watch value registers.
// - four resource watch control registers at the top of the map.
`ifndef BPWU_PARAMS_SVH
`define BPWU_PARAMS_SVH
`define BPWU_PS_TYPE      8'h0B
`define BPWU_NO_REPLY     8'hFF
`define BPWU_OFF_SSP      8'h12
`define BPWU_OFF_RRTHR    8'h13
`define BPWU_OFF_RRREG    8'h14
`define BPWU_OFF_CAUSE    8'h15
`define BPWU_OFF_IADDR    8'h30
`define BPWU_OFF_ICTL     8'h40
`define BPWU_OFF_DA1      8'h50
`define BPWU_OFF_DA2      8'h60
`define BPWU_OFF_DCTL     8'h70
`define BPWU_OFF_RMASK    8'h80
`define BPWU_OFF_RVAL     8'h90
`define BPWU_OFF_RCTL     8'h9C
`define BPWU_FULL_WMASK   32'hFFFFFFFF
`define BPWU_ICTL_WMASK   32'h00FF0003
`define BPWU_DCTL_WMASK   32'h00FF0007
`define BPWU_RCTL_WMASK   32'h00FF0001
`define BPWU_EN_BIT       0
`define BPWU_MODE_BIT     1
`define BPWU_LOAD_BIT     2
`define BPWU_TMASK_LO     16
`define BPWU_CTHR_LO      8
`define BPWU_CIDX_LO      16
`define BPWU_NTHR         8
`define BPWU_REP_BYTES    4
`endif

/* File: hw/bpwu_pkg.sv */
// bpwu_pkg.sv: types of the breakpoint unit
package bpwu_pkg;
  typedef enum logic [2:0] {
    BPWU_C_NONE   = 3'h0,
    BPWU_C_HOST   = 3'h1,
    BPWU_C_DEBUG_CALL_INSTRUCTION  = 3'h2,
    BPWU_C_IBRK   = 3'h3,
    BPWU_C_DWATCH = 3'h4,
    BPWU_C_RWATCH = 3'h5
  } bpwu_cause_e;
  typedef enum logic [1:0] {
    BPWU_REP_IDLE = 2'b01,
    BPWU_REP_SEND = 2'b10
  } bpwu_rep_e;
  typedef logic [31:0] bpwu_word_t;
endpackage

/* File: hw/bpwu_ibrk.sv */
// bpwu_ibrk.sv: one instruction breakpoint comparator
`timescale 1ns/1ps
`include "bpwu_params.svh"
module bpwu_ibrk (
  // setup
  input  wire bpwu_pkg::bpwu_word_t addr_in,
  input  wire bpwu_pkg::bpwu_word_t ctl_in,
  // fetch
  input  wire logic                 valid_in,
  input  wire logic [7:0]           thread_in,
  input  wire bpwu_pkg::bpwu_word_t pc_in,
  // result
  output logic                      hit_out
);
  import bpwu_pkg::*;
  logic thr_ok;
  logic pc_ok;
  assign thr_ok = (thread_in < 8'(`BPWU_NTHR)) && ctl_in[`BPWU_TMASK_LO + 32'(thread_in[2:0])];
  assign pc_ok = ctl_in[`BPWU_MODE_BIT] ? (pc_in != addr_in) : (pc_in == addr_in);
  assign hit_out = valid_in && ctl_in[`BPWU_EN_BIT] && thr_ok && pc_ok;
endmodule

/* File: hw/bpwu_dwatch.sv */
// bpwu_dwatch.sv: one data watchpoint comparator
`timescale 1ns/1ps
`include "bpwu_params.svh"
module bpwu_dwatch (
  // setup
  input  wire bpwu_pkg::bpwu_word_t addr1_in,
  input  wire bpwu_pkg::bpwu_word_t addr2_in,
  input  wire bpwu_pkg::bpwu_word_t ctl_in,
  // access
  input  wire logic                 valid_in,
  input  wire logic                 load_in,
  input  wire logic [7:0]           thread_in,
  input  wire bpwu_pkg::bpwu_word_t addr_in,
  // result
  output logic                      hit_out
);
  import bpwu_pkg::*;
  logic thr_ok;
  logic m1;
  logic m2;
  logic cond_ok;
  assign thr_ok = (thread_in < 8'(`BPWU_NTHR)) && ctl_in[`BPWU_TMASK_LO + 32'(thread_in[2:0])];
  assign m1 = (addr_in == addr1_in);
  assign m2 = (addr_in == addr2_in);
  assign cond_ok = ctl_in[`BPWU_MODE_BIT] ? (m1 || m2) : (m1 && m2);
  assign hit_out = valid_in && ctl_in[`BPWU_EN_BIT] && thr_ok && cond_ok &&
                   (!load_in || ctl_in[`BPWU_LOAD_BIT]);
endmodule

/* File: hw/bpwu_top.sv */
// bpwu_top.sv: breakpoint, watchpoint and debug cause unit of one tile
`timescale 1ns/1ps
`include "bpwu_params.svh"
module bpwu_top (
  // clock and reset
  input  wire logic                  clock_in,
  input  wire logic                  rst_in,
  // processor status access
  input  wire logic                  ps_write_in,
  input  wire logic                  ps_read_in,
  input  wire bpwu_pkg::bpwu_word_t  ps_resource_in,
  input  wire bpwu_pkg::bpwu_word_t  ps_wdata_in,
  output bpwu_pkg::bpwu_word_t       ps_rdata_out,
  output logic                       ps_rvalid_out,
  // configuration messages
  input  wire logic                  cfg_valid_in,
  input  wire logic                  cfg_write_in,
  input  wire logic [23:0]           cfg_return_in,
  input  wire logic [7:0]            cfg_index_in,
  input  wire bpwu_pkg::bpwu_word_t  cfg_wdata_in,
  output logic                       cfg_ready_out,
  output logic                       rep_valid_out,
  output logic [23:0]                rep_dest_out,
  output logic [7:0]                 rep_byte_out,
  output logic                       rep_last_out,
  // core state and debug requests
  input  wire logic                  debug_mode_in,
  input  wire logic                  host_req_in,
  input  wire logic                  debug_call_instruction_in,
  input  wire logic [7:0]            debug_call_instruction_thread_in,
  input  wire bpwu_pkg::bpwu_word_t  sp_in,
  // fetch, memory and resource activity
  input  wire logic                  fetch_valid_in,
  input  wire logic [7:0]            fetch_thread_in,
  input  wire bpwu_pkg::bpwu_word_t  fetch_pc_in,
  input  wire logic                  mem_valid_in,
  input  wire logic                  mem_load_in,
  input  wire logic [7:0]            mem_thread_in,
  input  wire bpwu_pkg::bpwu_word_t  mem_addr_in,
  input  wire logic                  res_valid_in,
  input  wire logic [7:0]            res_thread_in,
  input  wire bpwu_pkg::bpwu_word_t  res_id_in,
  // debug results
  output logic                       dbg_irq_out,
  output bpwu_pkg::bpwu_cause_e      cause_out,
  output logic [7:0]                 rr_thread_out,
  output logic [4:0]                 rr_reg_out,
  output bpwu_pkg::bpwu_word_t       ssp_out
);
  import bpwu_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // banks: 0 iaddr 1 ictl 2 da1 3 da2 4 dctl 5 rmask 6 rval 7 rctl
  localparam int NB = 8;
  localparam int NC = 4;
  localparam logic [7:0] BANK_BASE [NB] = '{`BPWU_OFF_IADDR, `BPWU_OFF_ICTL,
    `BPWU_OFF_DA1, `BPWU_OFF_DA2, `BPWU_OFF_DCTL, `BPWU_OFF_RMASK,
    `BPWU_OFF_RVAL, `BPWU_OFF_RCTL};
  localparam bpwu_word_t BANK_WMASK [NB] = '{`BPWU_FULL_WMASK, `BPWU_ICTL_WMASK,
    `BPWU_FULL_WMASK, `BPWU_FULL_WMASK, `BPWU_DCTL_WMASK, `BPWU_FULL_WMASK,
    `BPWU_FULL_WMASK, `BPWU_RCTL_WMASK};
  bpwu_word_t  bank_r   [NB][NC];
  bpwu_word_t  bank_nxt [NB][NC];
  bpwu_word_t  ssp_r, ssp_nxt;
  logic [7:0]  rthr_r, rthr_nxt;
  logic [4:0]  rreg_r, rreg_nxt;
  bpwu_cause_e cause_r, cause_nxt;
  logic [7:0]  cthr_r, cthr_nxt;
  logic [1:0]  cidx_r, cidx_nxt;
  logic        irq_r, irq_nxt;
  bpwu_word_t  rdata_r, rdata_nxt;
  logic        rvalid_r, rvalid_nxt;
  bpwu_rep_e   rep_st_r, rep_st_nxt;
  logic [1:0]  rep_cnt_r, rep_cnt_nxt;
  bpwu_word_t  rep_data_r, rep_data_nxt;
  logic [23:0] rep_dest_r, rep_dest_nxt;
  logic        ps_type_ok, cfg_take, w_en, ev;
  logic [7:0]  ps_idx, w_idx, ethr;
  bpwu_word_t  w_data;
  logic [NC-1:0] ih, dh, rh;
  bpwu_cause_e ecause;
  logic [1:0]  eidx;
  function automatic logic [1:0] lowest(input logic [3:0] v);
    lowest = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (v[i]) lowest = 2'(i);
    end
  endfunction
  function automatic bpwu_word_t rd_val(input logic [7:0] idx);
    rd_val = 32'h00000000;
    unique case (idx)
      `BPWU_OFF_SSP:   rd_val = ssp_r;
      `BPWU_OFF_RRTHR: rd_val = {24'h000000, rthr_r};
      `BPWU_OFF_RRREG: rd_val = {27'h0000000, rreg_r};
      `BPWU_OFF_CAUSE: rd_val = {14'h0000, cidx_r, cthr_r, 5'h00, cause_r};
      default: begin
        for (int b = 0; b < NB; b++) begin
          for (int k = 0; k < NC; k++) begin
            if (idx == BANK_BASE[b] + 8'(k)) rd_val = bank_r[b][k];
          end
        end
      end
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // access decode
  // resource id split
  assign ps_type_ok = (ps_resource_in[7:0] == `BPWU_PS_TYPE);
  assign ps_idx     = ps_resource_in[15:8];
  // ps accesses win the cycle; a message waits for a quiet one
  assign cfg_ready_out = (rep_st_r == BPWU_REP_IDLE) && !ps_write_in && !ps_read_in;
  assign cfg_take      = cfg_valid_in && cfg_ready_out;
  assign w_en   = debug_mode_in && ((ps_write_in && ps_type_ok) || (cfg_take && cfg_write_in));
  assign w_idx  = ps_write_in ? ps_idx : cfg_index_in;
  assign w_data = ps_write_in ? ps_wdata_in : cfg_wdata_in;
  ////////////////////////////////////////////////////////////////////////////
  // comparators
  genvar k;
  generate
    for (k = 0; k < NC; k++) begin : g_cmp
      bpwu_ibrk u_ibrk (
        .addr_in   (bank_r[0][k]),
        .ctl_in    (bank_r[1][k]),
        .valid_in  (fetch_valid_in),
        .thread_in (fetch_thread_in),
        .pc_in     (fetch_pc_in),
        .hit_out   (ih[k])
      );
      bpwu_dwatch u_dwatch (
        .addr1_in  (bank_r[2][k]),
        .addr2_in  (bank_r[3][k]),
        .ctl_in    (bank_r[4][k]),
        .valid_in  (mem_valid_in),
        .load_in   (mem_load_in),
        .thread_in (mem_thread_in),
        .addr_in   (mem_addr_in),
        .hit_out   (dh[k])
      );
      assign rh[k] = res_valid_in && bank_r[7][k][`BPWU_EN_BIT] &&
        (res_thread_in < 8'(`BPWU_NTHR)) &&
        bank_r[7][k][`BPWU_TMASK_LO + 32'(res_thread_in[2:0])] &&
        ((res_id_in & bank_r[5][k]) == (bank_r[6][k] & bank_r[5][k]));
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////////
  // debug event selection, host first then call then comparators
  always_comb begin
    ecause = BPWU_C_NONE;
    ethr   = 8'h00;
    eidx   = 2'h0;
    if (host_req_in) begin
      ecause = BPWU_C_HOST;
    end else if (debug_call_instruction_in) begin
      ecause = BPWU_C_DEBUG_CALL_INSTRUCTION;
      ethr   = debug_call_instruction_thread_in;
    end else if (|ih) begin
      ecause = BPWU_C_IBRK;
      ethr   = fetch_thread_in;
      eidx   = lowest(ih);
    end else if (|dh) begin
      ecause = BPWU_C_DWATCH;
      ethr   = mem_thread_in;
      eidx   = lowest(dh);
    end else if (|rh) begin
      ecause = BPWU_C_RWATCH;
      ethr   = res_thread_in;
      eidx   = lowest(rh);
    end
  end
  // already in the handler: further hits are dropped, not queued
  assign ev = !debug_mode_in && (ecause != BPWU_C_NONE);
  ////////////////////////////////////////////////////////////////////////////
  // register state
  always_comb begin
    bank_nxt  = bank_r;
    ssp_nxt   = ssp_r;
    rthr_nxt  = rthr_r;
    rreg_nxt  = rreg_r;
    cause_nxt = cause_r;
    cthr_nxt  = cthr_r;
    cidx_nxt  = cidx_r;
    irq_nxt   = 1'b0;
    if (w_en) begin
      for (int b = 0; b < NB; b++) begin
        for (int c = 0; c < NC; c++) begin
          if (w_idx == BANK_BASE[b] + 8'(c)) bank_nxt[b][c] = w_data & BANK_WMASK[b];
        end
      end
      unique case (w_idx)
        `BPWU_OFF_SSP:   ssp_nxt = w_data;
        `BPWU_OFF_RRTHR: rthr_nxt = w_data[7:0];
        `BPWU_OFF_RRREG: rreg_nxt = w_data[4:0];
        `BPWU_OFF_CAUSE: begin
          cause_nxt = bpwu_cause_e'(w_data[2:0]);
          cthr_nxt  = w_data[`BPWU_CTHR_LO +: 8];
          cidx_nxt  = w_data[`BPWU_CIDX_LO +: 2];
        end
        default: begin
        end
      endcase
    end
    // event set wins over any write in the same cycle
    if (ev) begin
      irq_nxt   = 1'b1;
      ssp_nxt   = sp_in;
      cause_nxt = ecause;
      cthr_nxt  = ethr;
      cidx_nxt  = eidx;
    end
  end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      bank_r  <= '{default: 32'h00000000};
      ssp_r   <= 32'h00000000;
      rthr_r  <= 8'h00;
      rreg_r  <= 5'h00;
      cause_r <= BPWU_C_NONE;
      cthr_r  <= 8'h00;
      cidx_r  <= 2'h0;
      irq_r   <= 1'b0;
    end else begin
      bank_r  <= bank_nxt;
      ssp_r   <= ssp_nxt;
      rthr_r  <= rthr_nxt;
      rreg_r  <= rreg_nxt;
      cause_r <= cause_nxt;
      cthr_r  <= cthr_nxt;
      cidx_r  <= cidx_nxt;
      irq_r   <= irq_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // status read port and configuration reply
  always_comb begin
    rvalid_nxt   = ps_read_in;
    rdata_nxt    = rdata_r;
    rep_st_nxt   = rep_st_r;
    rep_cnt_nxt  = rep_cnt_r;
    rep_data_nxt = rep_data_r;
    rep_dest_nxt = rep_dest_r;
    if (ps_read_in) rdata_nxt = ps_type_ok ? rd_val(ps_idx) : 32'h00000000;
    unique case (rep_st_r)
      BPWU_REP_IDLE: begin
        if (cfg_take && !(cfg_write_in && cfg_return_in[7:0] == `BPWU_NO_REPLY)) begin
          rep_st_nxt   = BPWU_REP_SEND;
          rep_cnt_nxt  = 2'h0;
          rep_data_nxt = cfg_write_in ? 32'h00000000 : rd_val(cfg_index_in);
          rep_dest_nxt = cfg_return_in;
        end
      end
      BPWU_REP_SEND: begin
        rep_data_nxt = {rep_data_r[23:0], 8'h00};
        rep_cnt_nxt  = rep_cnt_r + 2'h1;
        if (rep_cnt_r == 2'(`BPWU_REP_BYTES - 1)) begin
          rep_st_nxt = BPWU_REP_IDLE;
        end
      end
      default: rep_st_nxt = BPWU_REP_IDLE;
    endcase
  end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rvalid_r   <= 1'b0;
      rdata_r    <= 32'h00000000;
      rep_st_r   <= BPWU_REP_IDLE;
      rep_cnt_r  <= 2'h0;
      rep_data_r <= 32'h00000000;
      rep_dest_r <= 24'h000000;
    end else begin
      rvalid_r   <= rvalid_nxt;
      rdata_r    <= rdata_nxt;
      rep_st_r   <= rep_st_nxt;
      rep_cnt_r  <= rep_cnt_nxt;
      rep_data_r <= rep_data_nxt;
      rep_dest_r <= rep_dest_nxt;
    end
  end
  assign ps_rdata_out  = rdata_r;
  assign ps_rvalid_out = rvalid_r;
  assign rep_valid_out = (rep_st_r == BPWU_REP_SEND);
  assign rep_byte_out  = rep_data_r[31:24];
  assign rep_last_out  = rep_valid_out && (rep_cnt_r == 2'(`BPWU_REP_BYTES - 1));
  assign rep_dest_out  = rep_dest_r;
  assign dbg_irq_out   = irq_r;
  assign cause_out     = cause_r;
  assign rr_thread_out = rthr_r;
  assign rr_reg_out    = rreg_r;
  assign ssp_out       = ssp_r;
  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  property p_ps_id;
    (ps_read_in && !ps_type_ok) |=> (ps_rvalid_out && ps_rdata_out == 32'h00000000);
  endproperty
  a_ps_id: assert property (p_ps_id) else $error("bad resource type read nonzero");
  property p_no_reply;
    (cfg_take && cfg_write_in && cfg_return_in[7:0] == `BPWU_NO_REPLY) |=> !rep_valid_out;
  endproperty
  a_no_reply: assert property (p_no_reply) else $error("reply sent when suppressed");
  property p_msb_first;
    (cfg_take && !cfg_write_in && cfg_index_in == `BPWU_OFF_RRTHR && !ps_write_in)
      |=> rep_byte_out == 8'h00 ##1 rep_byte_out == 8'h00 ##1 rep_byte_out == 8'h00
      ##1 (rep_last_out && rep_byte_out == $past(rr_thread_out, 4));
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("reply byte order wrong");
  property p_rr_thread;
    (debug_mode_in && ps_write_in && ps_type_ok && ps_idx == `BPWU_OFF_RRTHR)
      |=> rr_thread_out == 8'($past(ps_wdata_in));
  endproperty
  a_rr_thread: assert property (p_rr_thread) else $error("thread operand not stored");
  property p_rr_reg;
    (debug_mode_in && ps_write_in && ps_type_ok && ps_idx == `BPWU_OFF_RRREG)
      |=> rr_reg_out == 5'($past(ps_wdata_in));
  endproperty
  a_rr_reg: assert property (p_rr_reg) else $error("register operand not stored");
  property p_host_cause;
    (host_req_in && !debug_mode_in) |=> (dbg_irq_out && cause_out == BPWU_C_HOST);
  endproperty
  a_host_cause: assert property (p_host_cause) else $error("host cause not recorded");
  property p_debug_call_instruction_idx;
    (debug_call_instruction_in && !host_req_in && !debug_mode_in)
      |=> (cidx_r == 2'h0 && cthr_r == $past(debug_call_instruction_thread_in));
  endproperty
  a_debug_call_instruction_idx: assert property (p_debug_call_instruction_idx) else $error("call index or thread wrong");
  property p_lowest;
    (!debug_mode_in && !host_req_in && !debug_call_instruction_in && !ih[0] && ih[1]) |=> cidx_r == 2'h1;
  endproperty
  a_lowest: assert property (p_lowest) else $error("lowest comparator not taken");
  property p_host_thr;
    (host_req_in && !debug_mode_in) |=> cthr_r == 8'h00;
  endproperty
  a_host_thr: assert property (p_host_thr) else $error("host thread not zero");
  property p_ibrk_eq;
    (!debug_mode_in && !host_req_in && !debug_call_instruction_in && !ih[0] && fetch_valid_in &&
     bank_r[1][1][`BPWU_EN_BIT] && !bank_r[1][1][`BPWU_MODE_BIT] && fetch_thread_in < 8'h08 &&
     bank_r[1][1][`BPWU_TMASK_LO + 32'(fetch_thread_in[2:0])] && fetch_pc_in == bank_r[0][1])
      |=> (dbg_irq_out && cause_out == BPWU_C_IBRK && cidx_r == 2'h1);
  endproperty
  a_ibrk_eq: assert property (p_ibrk_eq) else $error("equal breakpoint missed");
  property p_drw_gate;
    !debug_mode_in |=> ($stable(rr_thread_out) && $stable(rr_reg_out));
  endproperty
  a_drw_gate: assert property (p_drw_gate) else $error("write taken outside debug mode");
  property p_ssp;
    ev |=> (ssp_out == $past(sp_in) && dbg_irq_out) ##1 (!dbg_irq_out || $past(ev));
  endproperty
  a_ssp: assert property (p_ssp) else $error("stack pointer not saved");
  c_host: cover property (host_req_in && !debug_mode_in ##1 dbg_irq_out);
  c_ibrk: cover property (dbg_irq_out && cause_out == BPWU_C_IBRK);
  c_dwatch: cover property (dbg_irq_out && cause_out == BPWU_C_DWATCH);
  c_reply: cover property (rep_last_out);
endmodule

/* File: testbench/bpwu_top_bench.sv */
// bpwu_top_bench.sv: self-checking bench of the breakpoint and watchpoint unit
`timescale 1ns/1ps
module bpwu_top_bench;
  import bpwu_pkg::*;
  logic        clock_in, rst_in, ps_write_in, ps_read_in, ps_rvalid_out;
  logic [31:0] ps_resource_in, ps_wdata_in, ps_rdata_out, cfg_wdata_in, sp_in;
  logic        cfg_valid_in, cfg_write_in, cfg_ready_out, rep_valid_out, rep_last_out;
  logic [23:0] cfg_return_in, rep_dest_out, exp_dest;
  logic [7:0]  cfg_index_in, rep_byte_out, debug_call_instruction_thread_in, rr_thread_out;
  logic        debug_mode_in, host_req_in, debug_call_instruction_in, fetch_valid_in, mem_valid_in;
  logic        mem_load_in, res_valid_in, dbg_irq_out;
  logic [7:0]  fetch_thread_in, mem_thread_in, res_thread_in;
  logic [31:0] fetch_pc_in, mem_addr_in, res_id_in, ssp_out, rep_w, r;
  logic [4:0]  rr_reg_out;
  bpwu_cause_e cause_out;
  logic [31:0] exp_q[$];
  logic [15:0] seed = 16'hD087;
  logic [7:0]  o;
  int          miscompares = 0;
  int          total_checks = 0;
  logic [7:0]  offs [12] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h30, 8'h40, 8'h50, 8'h60,
                             8'h70, 8'h80, 8'h90, 8'h9C};
  logic [31:0] msk [12] = '{32'hFFFFFFFF, 32'hFF, 32'h1F, 32'h3FF07, 32'hFFFFFFFF,
                            32'hFF0003, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFF0007,
                            32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFF0001};

  bpwu_top bpwu_top_i (
    .clock_in(clock_in), .rst_in(rst_in), .ps_write_in(ps_write_in),
    .ps_read_in(ps_read_in), .ps_resource_in(ps_resource_in), .ps_wdata_in(ps_wdata_in),
    .ps_rdata_out(ps_rdata_out), .ps_rvalid_out(ps_rvalid_out), .cfg_valid_in(cfg_valid_in),
    .cfg_write_in(cfg_write_in), .cfg_return_in(cfg_return_in), .cfg_index_in(cfg_index_in),
    .cfg_wdata_in(cfg_wdata_in), .cfg_ready_out(cfg_ready_out),
    .rep_valid_out(rep_valid_out), .rep_dest_out(rep_dest_out),
    .rep_byte_out(rep_byte_out), .rep_last_out(rep_last_out),
    .debug_mode_in(debug_mode_in), .host_req_in(host_req_in), .debug_call_instruction_in(debug_call_instruction_in),
    .debug_call_instruction_thread_in(debug_call_instruction_thread_in), .sp_in(sp_in), .fetch_valid_in(fetch_valid_in),
    .fetch_thread_in(fetch_thread_in), .fetch_pc_in(fetch_pc_in),
    .mem_valid_in(mem_valid_in), .mem_load_in(mem_load_in), .mem_thread_in(mem_thread_in),
    .mem_addr_in(mem_addr_in), .res_valid_in(res_valid_in), .res_thread_in(res_thread_in),
    .res_id_in(res_id_in), .dbg_irq_out(dbg_irq_out), .cause_out(cause_out),
    .rr_thread_out(rr_thread_out), .rr_reg_out(rr_reg_out), .ssp_out(ssp_out)
  );

  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [31:0] nextr();
    logic [15:0] a;
    a = step(seed);
    seed = step(a);
    return {a, seed};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // results that nobody announced count as mismatches
  task automatic pop(input logic [31:0] got);
    if (exp_q.size() == 0) check(got, (got === 32'h0) ? 32'h1 : 32'h0);
    else check(got, exp_q.pop_front());
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic drain;
    for (int n = 0; exp_q.size() != 0; n++) begin
      @(negedge clock_in);
      if (n > 40) begin
        miscompares++;
        finish_test();
      end
    end
  endtask

  // watcher: outputs are registered, so the falling edge sees them settled
  always @(negedge clock_in) begin
    if (ps_rvalid_out) pop(ps_rdata_out);
    if (dbg_irq_out) pop({29'h0, cause_out});
    if (rep_valid_out) rep_w = {rep_w[23:0], rep_byte_out};
    if (rep_valid_out) check({31'h0, cfg_ready_out}, 32'h0);
    if (rep_valid_out && rep_last_out) begin
      check({8'h0, rep_dest_out}, {8'h0, exp_dest});
      pop(rep_w);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic ps(input logic wr, input logic [7:0] idx, input logic [31:0] d,
                    input logic [7:0] ty);
    ps_write_in = wr;
    ps_read_in = !wr;
    ps_resource_in = {16'h0, idx, ty};
    ps_wdata_in = d;
    @(negedge clock_in);
    ps_write_in = 1'b0;
    ps_read_in = 1'b0;
    @(negedge clock_in);
    drain();
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    ps(1'b1, idx, d, 8'h0B);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    exp_q.push_back(e);
    ps(1'b0, idx, 32'h0, 8'h0B);
  endtask

  // request held until a falling edge shows ready, so the next rising edge takes it
  task automatic cfg(input logic w, input logic [7:0] idx, input logic [31:0] d,
                     input logic [23:0] ret);
    {cfg_valid_in, cfg_write_in, cfg_index_in} = {1'b1, w, idx};
    {cfg_wdata_in, cfg_return_in} = {d, ret};
    exp_dest = ret;
    for (int n = 0; n < 20 && cfg_ready_out !== 1'b1; n++) @(negedge clock_in);
    if (cfg_ready_out !== 1'b1) begin
      miscompares++;
      finish_test();
    end
    @(negedge clock_in);
    cfg_valid_in = 1'b0;
    drain();
  endtask

  // caller raises the source; irq, then cause word and saved pointer are checked
  task automatic fire(input logic [31:0] sp, input logic [2:0] c, input logic [1:0] ix,
                      input logic [7:0] th);
    sp_in = sp;
    debug_mode_in = 1'b0;
    exp_q.push_back({29'h0, c});
    @(negedge clock_in);
    check(ssp_out, sp);
    {host_req_in, debug_call_instruction_in, fetch_valid_in, mem_valid_in, res_valid_in} = 5'h0;
    debug_mode_in = 1'b1;
    drain();
    rd(8'h15, {14'h0, ix, th, 5'h0, c});
    rd(8'h12, sp);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {ps_write_in, ps_read_in, ps_resource_in, ps_wdata_in, cfg_valid_in, cfg_write_in,
     cfg_return_in, cfg_index_in, cfg_wdata_in, debug_mode_in, host_req_in, debug_call_instruction_in,
     debug_call_instruction_thread_in, sp_in, fetch_valid_in, fetch_thread_in, fetch_pc_in, mem_valid_in,
     mem_load_in, mem_thread_in, mem_addr_in, res_valid_in, res_thread_in, res_id_in} = '0;
    exp_dest = 24'h0;
    rep_w = 32'h0;
    rst_in = 1'b1;
    repeat (12) @(negedge clock_in);
    rst_in = 1'b0;
    rd(8'h15, 32'h0);
    wr(8'h30, 32'h12345678);
    rd(8'h30, 32'h0);
    debug_mode_in = 1'b1;
    for (int i = 0; i < 12; i++) begin
      r = nextr();
      o = (i < 4) ? offs[i] : offs[i] + {6'h0, r[1:0]};
      wr(o, r);
      rd(o, r & msk[i]);
      wr(o, 32'h0);
    end
    wr(8'h13, 32'hFFFFFF5A);
    ps(1'b1, 8'h13, 32'hA5, 8'h0A);
    exp_q.push_back(32'h0);
    ps(1'b0, 8'h13, 32'h0, 8'h0A);
    rd(8'h13, 32'h5A);
    rd(8'h20, 32'h0);
    wr(8'h14, 32'hFFFFFFEB);
    check({24'h0, rr_thread_out}, 32'h5A);
    check({27'h0, rr_reg_out}, 32'hB);
    // config messages: reply, suppressed reply, dropped write
    exp_q.push_back(32'h5A);
    cfg(1'b0, 8'h13, 32'h0, 24'h3C2A17);
    cfg(1'b1, 8'h90, 32'h87654321, 24'h1234FF);
    repeat (6) @(negedge clock_in);
    rd(8'h90, 32'h87654321);
    r = nextr();
    exp_q.push_back(32'h0);
    cfg(1'b1, 8'h91, r, 24'h123400);
    rd(8'h91, r);
    debug_mode_in = 1'b0;
    exp_q.push_back(32'h0);
    cfg(1'b1, 8'h92, r, 24'h555501);
    debug_mode_in = 1'b1;
    rd(8'h92, 32'h0);
    // comparators
    wr(8'h30, 32'h1000);
    wr(8'h31, 32'h1000);
    wr(8'h32, 32'h1000);
    wr(8'h40, 32'h00080001);
    wr(8'h41, 32'h00040001);
    wr(8'h42, 32'h00040001);
    {fetch_valid_in, fetch_thread_in, fetch_pc_in} = {1'b1, 8'h02, 32'h1000};
    fire(nextr(), 3'h3, 2'h1, 8'h02);
    wr(8'h41, 32'h0);
    wr(8'h42, 32'h0);
    wr(8'h33, 32'h2000);
    wr(8'h43, 32'h00200003);
    {fetch_valid_in, fetch_thread_in, fetch_pc_in} = {1'b1, 8'h05, 32'h2004};
    fire(nextr(), 3'h3, 2'h3, 8'h05);
    wr(8'h43, 32'h0);
    wr(8'h50, 32'h300);
    wr(8'h60, 32'h300);
    wr(8'h70, 32'h00020005);
    {mem_valid_in, mem_load_in, mem_thread_in, mem_addr_in} = {2'b11, 8'h01, 32'h300};
    fire(nextr(), 3'h4, 2'h0, 8'h01);
    wr(8'h70, 32'h0);
    wr(8'h51, 32'h400);
    wr(8'h61, 32'h500);
    wr(8'h71, 32'h00020003);
    {mem_valid_in, mem_load_in, mem_thread_in, mem_addr_in} = {2'b10, 8'h01, 32'h500};
    fire(nextr(), 3'h4, 2'h1, 8'h01);
    wr(8'h71, 32'h0);
    wr(8'h82, 32'hFF00);
    wr(8'h92, 32'h1234);
    wr(8'h9E, 32'h00010001);
    {res_valid_in, res_thread_in, res_id_in} = {1'b1, 8'h00, 32'h12FF};
    fire(nextr(), 3'h5, 2'h2, 8'h00);
    wr(8'h9E, 32'h0);
    host_req_in = 1'b1;
    fire(nextr(), 3'h1, 2'h0, 8'h00);
    {debug_call_instruction_in, debug_call_instruction_thread_in} = {1'b1, 8'h06};
    fire(nextr(), 3'h2, 2'h0, 8'h06);
    finish_test();
  end
endmodule
